// file: rtl/tbs_pkg.sv
// Package for the PWM time base and synchronisation block.
`default_nettype none
package tbs_pkg;
  localparam logic [3:0] TBS_ADDR_SYNC = 4'h0;
  localparam logic [3:0] TBS_ADDR_CNT_LO = 4'h4;
  localparam logic [3:0] TBS_ADDR_CNT_HI = 4'h8;
  localparam logic [3:0] TBS_ADDR_DUTY_LO = 4'hc;
  localparam logic [7:0] TBS_SYNC_RESET = 8'h00;
  localparam logic [15:0] TBS_CNT_RESET = 16'h0100;
  localparam logic [15:0] TBS_DUTY_RESET = 16'hffff;
  localparam int TBS_POFST_BIT = 7;
  localparam int TBS_PRPOL_BIT = 6;
  localparam int TBS_DCPOL_BIT = 5;
  localparam logic [7:0] TBS_SYNC_WMASK = 8'he7;
  localparam logic [2:0] TBS_SEL_OWN = 3'h0;
  localparam logic [2:0] TBS_SEL_RESERVED = 3'h4;

  typedef enum logic [1:0] {
    TBS_IDLE = 2'b00,
    TBS_DONE = 2'b01
  } tbs_bus_state_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } tbs_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } tbs_av_rsp_t;

  typedef struct packed {
    logic sync_out;
    logic latch_set;
    logic duty_fall;
    logic period_restart;
    logic period_async;
    logic duty_async;
  } tbs_events_t;
endpackage
`default_nettype wire

// file: rtl/tbs_timebase_sync.sv
// Time base counter, duty match and synchronisation routing with an Avalon-MM register slave.
// Operation
// (R01) Phase offset bit 1: sync out from phase, latch set from period.
// (R02) Period polarity bit inverts selected asynchronous period event inputs; 0 passes.
// (R03) Duty polarity bit 1 inverts asynchronous duty inputs; 0 passes them.
// (R04) Counter bits 7..0 are a readable, writable low byte register.
// (R05) Counter bits 15..8 are a readable, writable high byte register.
// (R06) Counter equal to duty compare value produces a falling edge event.
// (R07) Sync select 0 uses own period; others use companion sync; 4 reserved.
`default_nettype none
module tbs_timebase_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire tbs_pkg::tbs_av_req_t av_req,
  output var tbs_pkg::tbs_av_rsp_t av_rsp,
  input wire logic period_match,
  input wire logic phase_match,
  input wire logic [3:0] companion_sync,
  input wire logic period_async_in,
  input wire logic duty_async_in,
  output var tbs_pkg::tbs_events_t events,
  output var logic [15:0] timebase_counter
);
  import tbs_pkg::*;

  // Every output of the block is taken straight from this registered state.
  typedef struct packed {
    tbs_bus_state_t st;
    logic waitrequest;
    logic [31:0] rdata;
    logic [7:0] sync_control;
    logic [15:0] count;
    logic [15:0] duty_compare_value;
    tbs_events_t ev;
  } tbs_state_t;

  tbs_state_t q;
  tbs_state_t next_q;
  logic phase_offset_ctrl;
  logic period_event_invert;
  logic duty_event_invert;
  logic [2:0] period_sync_select;
  logic restart;
  logic [1:0] routed;
  logic bus_take;
  logic [31:0] read_word;

  // Merges the writable bits of a byte; bits outside the mask keep their old value.
  function automatic logic [7:0] tbs_merge(
    input logic [7:0] old,
    input logic [7:0] nw,
    input logic [7:0] m
  );
    tbs_merge = (old & ~m) | (nw & m);
  endfunction

  // True for the select code that must not be used.
  function automatic logic tbs_select_reserved(
    input logic [2:0] sel
  );
    tbs_select_reserved = (sel == TBS_SEL_RESERVED);
  endfunction

  // Picks the event that restarts the period from the select field.
  // The reserved code selects nothing, so a stray write there stops restarts
  // rather than borrowing an unrelated companion output.
  function automatic logic tbs_restart_source(
    input logic [2:0] sel,
    input logic own_period,
    input logic [3:0] companion
  );
    logic src;

    src = 1'b0;
    case (sel)
      TBS_SEL_OWN: begin
        src = own_period;
      end

      3'h1: begin
        src = companion[0];
      end

      3'h2: begin
        src = companion[1];
      end

      3'h3: begin
        src = companion[2];
      end

      default: begin
        src = companion[3];
      end
    endcase
    if (tbs_select_reserved(sel)) begin
      src = 1'b0;
    end
    tbs_restart_source = src;
  endfunction

  // Applies a polarity control bit to an asynchronous event input.
  function automatic logic tbs_polarity(
    input logic event_in,
    input logic invert
  );
    tbs_polarity = event_in ^ invert;
  endfunction

  // Next counter value: cleared by the restart event, otherwise one step up.
  // The counter wraps at the top silently; overflow is handled outside this block.
  function automatic logic [15:0] tbs_next_count(
    input logic [15:0] count,
    input logic clear
  );
    logic [15:0] result;

    result = count + 16'h0001;
    if (clear) begin
      result = 16'h0000;
    end
    tbs_next_count = result;
  endfunction

  // Widens a byte to a bus word with zeros above it.
  function automatic logic [31:0] tbs_byte_word(
    input logic [7:0] value
  );
    tbs_byte_word = {24'h000000, value};
  endfunction

  // True when a request writes the given offset.
  function automatic logic tbs_write_hit(
    input tbs_av_req_t req,
    input logic [3:0] target
  );
    tbs_write_hit = req.write && (req.address == target);
  endfunction

  // Routes the sync output (bit 1) and the latch set (bit 0).
  // In offset mode the latch follows the selected restart, the synchronous period event.
  function automatic logic [1:0] tbs_route(
    input logic offset_mode,
    input logic phase_ev,
    input logic period_ev,
    input logic sync_period_ev
  );
    logic [1:0] pair;

    pair = {period_ev, phase_ev};
    if (offset_mode) begin
      pair = {phase_ev, sync_period_ev};
    end
    tbs_route = pair;
  endfunction

  // Read multiplexer; unmapped offsets and unimplemented bits read as zero.
  function automatic logic [31:0] tbs_read_mux(
    input logic [3:0] addr,
    input logic [7:0] sync,
    input logic [15:0] count,
    input logic [15:0] duty
  );
    logic [31:0] word;

    word = 32'h00000000;
    case (addr)
      TBS_ADDR_SYNC: begin
        word = tbs_byte_word(sync & TBS_SYNC_WMASK);
      end

      TBS_ADDR_CNT_LO: begin
        word = tbs_byte_word(count[7:0]); // R04
      end

      TBS_ADDR_CNT_HI: begin
        word = tbs_byte_word(count[15:8]); // R05
      end

      TBS_ADDR_DUTY_LO: begin
        word = {16'h0000, duty};
      end

      default: begin
        word = 32'h00000000;
      end
    endcase
    tbs_read_mux = word;
  endfunction

  always_comb begin
    next_q = q;
    // Named views of the control fields.
    phase_offset_ctrl = q.sync_control[TBS_POFST_BIT];
    period_event_invert = q.sync_control[TBS_PRPOL_BIT];
    duty_event_invert = q.sync_control[TBS_DCPOL_BIT];
    period_sync_select = q.sync_control[2:0];
    bus_take = 1'b0;
    read_word = 32'h00000000;

    restart = tbs_restart_source(
      period_sync_select,
      period_match,
      companion_sync
    ); // R07
    routed = tbs_route(
      phase_offset_ctrl,
      phase_match,
      period_match,
      restart
    ); // R01

    // Time base: counts on every clock and restarts on the selected event.
    next_q.count = tbs_next_count(q.count, restart); // R07

    // Event outputs are registered, one clock after their cause.
    next_q.ev.sync_out = routed[1]; // R01
    next_q.ev.latch_set = routed[0]; // R01
    next_q.ev.period_restart = restart; // R07
    next_q.ev.period_async = tbs_polarity(
      period_async_in,
      period_event_invert
    ); // R02
    next_q.ev.duty_async = tbs_polarity(
      duty_async_in,
      duty_event_invert
    ); // R03
    // The compare sees the present count, so the event lags the match by one clock.
    next_q.ev.duty_fall = (q.count == q.duty_compare_value); // R06

    // A request is taken in idle and answered one clock later. Waitrequest is a flop,
    // so the answer costs a wait state but no decode glitch reaches the master.
    case (q.st)
      TBS_IDLE: begin
        next_q.waitrequest = 1'b1;
        if (av_req.read || av_req.write) begin
          bus_take = 1'b1;
        end
      end

      TBS_DONE: begin
        next_q.st = TBS_IDLE;
        next_q.waitrequest = 1'b1;
      end

      default: begin
        next_q.st = TBS_IDLE;
        next_q.waitrequest = 1'b1;
      end
    endcase

    if (bus_take) begin
      next_q.st = TBS_DONE;
      next_q.waitrequest = 1'b0;
      read_word = tbs_read_mux(
        av_req.address,
        q.sync_control,
        q.count,
        q.duty_compare_value
      ); // R04 R05
      next_q.rdata = read_word;
    end

    // A byte write lands at the take edge and wins over counting for that byte only.
    if (bus_take && tbs_write_hit(av_req, TBS_ADDR_SYNC)) begin
      next_q.sync_control = tbs_merge(
        q.sync_control,
        av_req.writedata[7:0],
        TBS_SYNC_WMASK
      );
    end

    if (bus_take && tbs_write_hit(av_req, TBS_ADDR_CNT_LO)) begin
      next_q.count[7:0] = av_req.writedata[7:0]; // R04
    end

    if (bus_take && tbs_write_hit(av_req, TBS_ADDR_CNT_HI)) begin
      next_q.count[15:8] = av_req.writedata[7:0]; // R05
    end

    if (bus_take && tbs_write_hit(av_req, TBS_ADDR_DUTY_LO)) begin
      next_q.duty_compare_value = av_req.writedata[15:0];
    end
  end

  // The reset branch loads constants only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q.st <= TBS_IDLE;
      q.waitrequest <= 1'b1;
      q.rdata <= 32'h00000000;
      q.sync_control <= TBS_SYNC_RESET;
      q.count <= TBS_CNT_RESET;
      q.duty_compare_value <= TBS_DUTY_RESET;
      q.ev <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Outputs are plain wires from the state flops.
  assign av_rsp = '{readdata: q.rdata, waitrequest: q.waitrequest};
  assign events = q.ev;
  assign timebase_counter = q.count;
endmodule
`default_nettype wire

// file: tb/tbs_props.sv
// Assertions on the time base block ports.
`default_nettype none
module tbs_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire tbs_pkg::tbs_av_req_t av_req,
  input wire logic period_match,
  input wire logic phase_match,
  input wire logic period_async_in,
  input wire logic duty_async_in,
  input wire tbs_pkg::tbs_events_t events,
  input wire tbs_pkg::tbs_av_rsp_t av_rsp,
  input wire logic [15:0] timebase_counter
);
  logic [7:0] sc;
  logic [15:0] dc;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) sc <= 8'h00;
    else if (av_req.write && av_req.address == 4'h0) sc <= av_req.writedata[7:0] & 8'he7;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) dc <= 16'hffff;
    else if (av_req.write && av_req.address == 4'hc) dc <= av_req.writedata[15:0];
  property p_src; !av_req.write && !sc[2:0] |=> events.sync_out == (sc[7] ? $past(phase_match) : $past(period_match))
    && events.latch_set == (sc[7] ? $past(period_match) : $past(phase_match)); endproperty
  a_src: assert property (p_src) else $error("bad source");
  property p_pol; !av_req.write |=> events.period_async == ($past(period_async_in) ^ sc[6])
    && events.duty_async == ($past(duty_async_in) ^ sc[5]); endproperty
  a_pol: assert property (p_pol) else $error("bad polarity");
  property p_rst; !av_req.write && !sc[1:0] |=> events.period_restart == (!sc[2] && $past(period_match)); endproperty
  a_rst: assert property (p_rst) else $error("bad restart");
  property p_cnt; !av_req.write && sc[2:0] == 3'h4
    |=> timebase_counter == $past(timebase_counter) + 16'h0001; endproperty
  a_cnt: assert property (p_cnt) else $error("counter did not step");
  property p_clr; !av_req.write && sc[2:0] == 3'h0 && period_match |=> timebase_counter == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("counter not restarted");
  property p_duty; 1'b1 |=> events.duty_fall == ($past(timebase_counter) == $past(dc)); endproperty
  a_duty: assert property (p_duty) else $error("bad duty match event");
  property p_wait; !av_rsp.waitrequest |=> av_rsp.waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("answer held too long");
endmodule
bind tbs_timebase_sync tbs_props u_props (.clk, .rst_b, .av_req, .period_match, .phase_match,
  .period_async_in, .duty_async_in, .events, .av_rsp, .timebase_counter);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the time base block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tbs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, rnd = 1'b0;
  logic [7:0] ins = 8'h00;
  tbs_av_req_t rq = '0;
  tbs_av_rsp_t rs;
  int error_cnt = 0, total_checks = 0, cyc = 0, seed = 95;
  logic [7:0] expq[$];
  logic [12:0] ops[14] = '{13'h0000, 13'h1c10, 13'h0c10, 13'h0801, 13'h0200, 13'h1400, 13'h041f, 13'h18c3,
    13'h08c3, 13'h10ff, 13'h00e7, 13'h1000, 13'h1080, 13'h10e4};
  tbs_timebase_sync uut (.clk, .rst_b, .av_req(rq), .av_rsp(rs), .period_match(ins[0]), .phase_match(ins[1]),
    .companion_sync(ins[7:4]), .period_async_in(ins[2]), .duty_async_in(ins[3]), .events(), .timebase_counter());
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin error_cnt++; $display("ERROR readdata exp %h got %h", e, s); end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic [12:0] op);
    if (!op[12]) expq.push_back(op[7:0]);
    rq <= '{op[11:8], !op[12], op[12], {24'h0, op[7:0]}};
    do @(posedge clk); while (rs.waitrequest !== 1'b0);
    rq <= '0;
    rnd <= op[12] && op[11:8] == 4'h0;
    repeat (30) @(posedge clk);
    rnd <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rq.read && rs.waitrequest === 1'b0) chk(rs.readdata[7:0], expq.pop_front());
    if (rnd) ins <= 8'($random(seed));
    if (++cyc > 1000) error_cnt++;
    if (cyc > 1000) stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ops[i]) bus(ops[i]);
    stop_test;
  end
endmodule
`default_nettype wire
